// ===== src/wig_event_gate.sv
/*
 * Wake and interrupt event gating: pin wake enables and levels, link-up
 * wake on pin 7, interrupt endpoint report gating, a software status and
 * mask pair with one interrupt output.
 * Assumes pins are asynchronous; events, resets, power state and the
 * nonvolatile image come from logic on clk_sys.
 */
`timescale 1ns/10ps
`include "wig_params.svh"

// Contract
// - each set pin wake enable lets its pin wake; clear blocks it.
// - level select 0 wakes on low pin, 1 wakes on high pin.
// - a pin not in general purpose mode never wakes the device.
// - link-up enable plus pin 7 setup signals link up in suspend 0 or 3.
// - wake enables default from the nonvolatile image, zero without it.
// - usb or light soft reset restores wake enables to the loaded image.
// - protected resets leave the wake enable field unchanged.
// - always-on sends a packet every interval; else only after enabled events.
// - mac reset timeout report enable gates that event.
// - receive frame present report enable gates that event.
// - transmit halt report enable gates that event.
// - receive halt report enable gates that event.
// - transceiver interrupt report enable gates that event.
// - transmit fault report enable gates that event.
// - transmit buffer underrun report enable gates that event.
// - transmit buffer overrun report enable gates that event.
// - receive drop report enable gates that event.
// - per-pin report enables gate pin events.
module wig_event_gate
    import wig_pkg::*;
#(
    parameter int PINS = `WIG_PIN_COUNT
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [PINS-1:0] pin_level,
    input wire logic [PINS-1:0] pin_is_gpio,
    input wire logic pin7_link_cfg_ok,
    input wire logic link_up,
    input wire logic [1:0] power_state,
    input wire logic usb_reset,
    input wire logic light_soft_reset,
    input wire logic reset_protect,
    input wire logic eeprom_present,
    input wire logic eeprom_load_done,
    input wire logic [15:0] eeprom_wake_bytes,
    input wire logic [`WIG_MAC_EVENTS-1:0] mac_events,
    input wire logic poll_req,
    output logic poll_send,
    output logic poll_nak,
    output logic [31:0] poll_status,
    output logic pin_wake,
    output logic link_up_wake,
    output logic irq
);

    logic [PINS-1:0] pin_meta;
    logic [PINS-1:0] pin_sync;
    logic [PINS-1:0] pin_act_q;
    logic link_meta;
    logic link_sync;
    logic [1:0] sync_fill;
    logic [PINS-1:0] pin_wake_en;
    logic [PINS-1:0] wake_image;
    logic [PINS-1:0] pin_wake_level_sel;
    logic link_up_wake_en;
    logic [31:0] report_ctl;
    logic [`WIG_STAT_BITS-1:0] irq_status;
    logic [`WIG_STAT_BITS-1:0] irq_mask;
    logic [PINS-1:0] pin_active;
    logic [PINS-1:0] pin_edge;
    logic [`WIG_REPORT_SRC_BITS-1:0] report_src;
    logic [`WIG_REPORT_SRC_BITS-1:0] report_pend;
    logic next_pin_wake;
    logic next_link_wake;
    logic in_low_power;
    logic periodic_report_always;
    logic [`WIG_STAT_BITS-1:0] stat_set;
    logic [`WIG_STAT_BITS-1:0] stat_clr;
    logic [`WIG_STAT_BITS-1:0] next_irq_status;
    wig_poll_e poll_state;

    function automatic logic [31:0] wig_zext(input logic [`WIG_STAT_BITS-1:0] v);
        wig_zext = {{(32-`WIG_STAT_BITS){1'b0}}, v};
    endfunction

    function automatic logic hit(input logic [7:0] ofs);
        hit = reg_wr && (reg_addr == ofs);
    endfunction

    function automatic logic [PINS-1:0] wake_restore(input logic [PINS-1:0] img);
        wake_restore = eeprom_present ? img : '0;
    endfunction

    // pin synchroniser
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else if (clk_en) begin
            pin_meta <= pin_level;
            pin_sync <= pin_meta;
        end
    end

    // link level synchroniser
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
        end else if (clk_en) begin
            link_meta <= link_up;
            link_sync <= link_meta;
        end
    end

    // no pin edge until the synchroniser holds real levels, else reset fakes one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_fill <= 2'h0;
        end else if (clk_en) begin
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    // active level per pin, only in general purpose mode
    always_comb begin
        pin_active = ~(pin_sync ^ pin_wake_level_sel) & pin_is_gpio
                     & {PINS{sync_fill[1]}};
        pin_edge = pin_active & ~pin_act_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_act_q <= '0;
        end else if (clk_en) begin
            pin_act_q <= pin_active;
        end
    end

    // wake enable field with its nonvolatile image
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_image <= `WIG_RST_WAKE_EN;
        end else if (clk_en) begin
            if (eeprom_load_done) begin
                wake_image <= wake_restore(eeprom_wake_bytes[PINS-1:0]);
            end
        end
    end

    // load and restore win over a software write in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_wake_en <= `WIG_RST_WAKE_EN;
        end else if (clk_en) begin
            if (eeprom_load_done) begin
                pin_wake_en <= wake_restore(eeprom_wake_bytes[PINS-1:0]);
            end else if ((usb_reset || light_soft_reset) && !reset_protect) begin
                pin_wake_en <= wake_restore(wake_image);
            end else if ((usb_reset || light_soft_reset) && reset_protect) begin
                pin_wake_en <= pin_wake_en;
            end else if (hit(`WIG_OFS_WAKE_POL)) begin
                pin_wake_en <= reg_wdata[`WIG_WAKE_EN_LSB +: PINS];
            end
        end
    end

    // level selects
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_wake_level_sel <= `WIG_RST_LEVEL_SEL;
        end else if (clk_en) begin
            if (hit(`WIG_OFS_WAKE_POL)) begin
                pin_wake_level_sel <= reg_wdata[`WIG_LEVEL_SEL_LSB +: PINS];
            end
        end
    end

    // link-up wake control
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_up_wake_en <= 1'b0;
        end else if (clk_en) begin
            if (hit(`WIG_OFS_WAKE_POL)) begin
                link_up_wake_en <= reg_wdata[`WIG_LINK_UP_WAKE_BIT];
            end
        end
    end

    // interrupt endpoint control: always-on in 31, enables in 19:0, rest reads zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            report_ctl <= `WIG_RST_REPORT_CTL;
        end else if (clk_en) begin
            if (hit(`WIG_OFS_REPORT_CTL)) begin
                report_ctl <= {reg_wdata[`WIG_ALWAYS_BIT], 11'h000,
                               reg_wdata[`WIG_REPORT_SRC_BITS-1:0]};
            end
        end
    end

    // pin wake decision
    always_comb begin
        next_pin_wake = |(pin_active & pin_wake_en);
    end

    // link-up wake decision, only in suspend 0 or 3
    always_comb begin
        in_low_power = (power_state == WIG_ST_SUSP0) || (power_state == WIG_ST_SUSP3);
        next_link_wake = link_up_wake_en && pin7_link_cfg_ok && link_sync
                         && in_low_power && pin_is_gpio[`WIG_LINK_PIN];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_wake <= 1'b0;
        end else if (clk_en) begin
            pin_wake <= next_pin_wake;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link_up_wake <= 1'b0;
        end else if (clk_en) begin
            link_up_wake <= next_link_wake;
        end
    end

    // report sources: pins in 10:0, mac events in 19:11
    always_comb begin
        report_src = {irq_status[`WIG_REPORT_SRC_BITS-1:`WIG_MAC_REPORT_LSB],
                      irq_status[PINS-1:0]};
        report_pend[`WIG_MAC_REPORT_LSB+8] = report_src[19] & report_ctl[19];
        report_pend[`WIG_MAC_REPORT_LSB+7] = report_src[18] & report_ctl[18];
        report_pend[`WIG_MAC_REPORT_LSB+6] = report_src[17] & report_ctl[17];
        report_pend[`WIG_MAC_REPORT_LSB+5] = report_src[16] & report_ctl[16];
        report_pend[`WIG_MAC_REPORT_LSB+4] = report_src[15] & report_ctl[15];
        report_pend[`WIG_MAC_REPORT_LSB+3] = report_src[14] & report_ctl[14];
        report_pend[`WIG_MAC_REPORT_LSB+2] = report_src[13] & report_ctl[13];
        report_pend[`WIG_MAC_REPORT_LSB+1] = report_src[12] & report_ctl[12];
        report_pend[`WIG_MAC_REPORT_LSB] = report_src[11] & report_ctl[11];
        report_pend[PINS-1:0] = report_src[PINS-1:0] & report_ctl[PINS-1:0];
    end

    // sticky status, set wins over write-one-to-clear
    always_comb begin
        stat_set = '0;
        stat_set[PINS-1:0] = pin_edge;
        stat_set[`WIG_MAC_REPORT_LSB +: `WIG_MAC_EVENTS] = mac_events;
        stat_set[`WIG_STAT_PIN_WAKE_BIT] = next_pin_wake & ~pin_wake;
        stat_set[`WIG_STAT_LINK_WAKE_BIT] = next_link_wake & ~link_up_wake;
        stat_clr = hit(`WIG_OFS_IRQ_STATUS) ? reg_wdata[`WIG_STAT_BITS-1:0] : '0;
        next_irq_status = (irq_status & ~stat_clr) | stat_set;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= `WIG_RST_STAT;
        end else if (clk_en) begin
            irq_status <= next_irq_status;
        end
    end

    // mask of the same layout as status
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= `WIG_RST_STAT;
        end else if (clk_en) begin
            if (hit(`WIG_OFS_IRQ_MASK)) begin
                irq_mask <= reg_wdata[`WIG_STAT_BITS-1:0];
            end
        end
    end

    // irq follows the status of this edge, so it drops together with the clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // interrupt endpoint poll answer
    always_comb begin
        periodic_report_always = report_ctl[`WIG_ALWAYS_BIT];
        if (!poll_req) begin
            poll_state = WIG_POLL_IDLE;
        end else if (periodic_report_always || (|report_pend)) begin
            poll_state = WIG_POLL_SEND;
        end else begin
            poll_state = WIG_POLL_NAK;
        end
    end

    // one-cycle answer pulses
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            poll_send <= 1'b0;
            poll_nak <= 1'b0;
        end else if (clk_en) begin
            poll_send <= 1'b0;
            poll_nak <= 1'b0;
            case (poll_state)
                WIG_POLL_SEND: begin
                    poll_send <= 1'b1;
                end
                WIG_POLL_NAK: begin
                    poll_nak <= 1'b1;
                end
                WIG_POLL_IDLE: begin
                    poll_send <= 1'b0;
                end
                default: begin
                    poll_nak <= 1'b0;
                end
            endcase
        end
    end

    // status snapshot, held until the next packet is sent
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            poll_status <= '0;
        end else if (clk_en) begin
            if (poll_state == WIG_POLL_SEND) begin
                poll_status <= wig_zext(irq_status);
            end
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            if (reg_rd) begin
                case (reg_addr)
                    `WIG_OFS_WAKE_POL: begin
                        reg_rdata <= {link_up_wake_en, 4'h0, pin_wake_level_sel,
                                      5'h00, pin_wake_en};
                    end
                    `WIG_OFS_REPORT_CTL: begin
                        reg_rdata <= report_ctl;
                    end
                    `WIG_OFS_IRQ_STATUS: begin
                        reg_rdata <= wig_zext(irq_status);
                    end
                    `WIG_OFS_IRQ_MASK: begin
                        reg_rdata <= wig_zext(irq_mask);
                    end
                    default: begin
                        reg_rdata <= 32'h00000000;
                    end
                endcase
            end else begin
                reg_rdata <= 32'h00000000;
            end
        end
    end

endmodule // wig_event_gate

// ===== src/wig_params.svh
/*
 * Offsets, field positions, reset values and widths for the wake and
 * interrupt event gating block.
 * Assumes a 32-bit register port with byte addresses.
 */
`ifndef WIG_PARAMS_SVH
`define WIG_PARAMS_SVH

`define WIG_OFS_WAKE_POL 8'h64
`define WIG_OFS_REPORT_CTL 8'h68
`define WIG_OFS_IRQ_STATUS 8'h80
`define WIG_OFS_IRQ_MASK 8'h84

`define WIG_PIN_COUNT 11
`define WIG_MAC_EVENTS 9
`define WIG_WAKE_EN_LSB 0
`define WIG_LEVEL_SEL_LSB 16
`define WIG_LINK_UP_WAKE_BIT 31
`define WIG_ALWAYS_BIT 31
`define WIG_PIN_REPORT_LSB 0
`define WIG_MAC_REPORT_LSB 11
`define WIG_REPORT_SRC_BITS 20
`define WIG_STAT_PIN_WAKE_BIT 20
`define WIG_STAT_LINK_WAKE_BIT 21
`define WIG_STAT_BITS 22
`define WIG_LINK_PIN 7

`define WIG_RST_WAKE_EN 11'h000
`define WIG_RST_LEVEL_SEL 11'h000
`define WIG_RST_REPORT_CTL 32'h00000000
`define WIG_RST_STAT 22'h000000

`endif

// ===== src/wig_pkg.sv
/*
 * Types for the wake and interrupt event gating block.
 * Assumes the constants header is included by the design file.
 */
package wig_pkg;
    typedef logic [1:0] wig_pstate_t;
    typedef enum logic [1:0] {
        WIG_ST_ACTIVE,
        WIG_ST_SUSP0,
        WIG_ST_SUSP1_2,
        WIG_ST_SUSP3
    } wig_power_e;
    typedef enum {
        WIG_POLL_IDLE,
        WIG_POLL_SEND,
        WIG_POLL_NAK
    } wig_poll_e;
endpackage

// ===== tb/tb.sv
/* self-checking bench for wig_event_gate with host poll model and checker.
   assumes 100 MHz clk_sys and clk_en held high. */
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic [10:0] pin_level = 11'h000;
    logic [10:0] pin_is_gpio = 11'h000;
    logic pin7_link_cfg_ok = 1'h0;
    logic link_up = 1'h0;
    logic [1:0] power_state = 2'h0;
    logic [2:0] ctl_pulse = 3'h0;
    logic reset_protect = 1'h0;
    logic eeprom_present = 1'h0;
    logic [15:0] eeprom_wake_bytes = 16'h0000;
    logic [8:0] mac_events = 9'h000;
    logic poll_req, poll_send, poll_nak, last_send, pin_wake, link_up_wake, irq;
    logic [31:0] poll_status, last_status;
    logic [15:0] answers;
    int num_errors = 0;
    int compares = 0;
    always #5 clk_sys = ~clk_sys;
    wig_event_gate i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'h1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_level(pin_level), .pin_is_gpio(pin_is_gpio),
        .pin7_link_cfg_ok(pin7_link_cfg_ok), .link_up(link_up), .power_state(power_state),
        .usb_reset(ctl_pulse[0]), .light_soft_reset(ctl_pulse[1]),
        .reset_protect(reset_protect), .eeprom_present(eeprom_present),
        .eeprom_load_done(ctl_pulse[2]), .eeprom_wake_bytes(eeprom_wake_bytes),
        .mac_events(mac_events), .poll_req(poll_req), .poll_send(poll_send),
        .poll_nak(poll_nak), .poll_status(poll_status), .pin_wake(pin_wake),
        .link_up_wake(link_up_wake), .irq(irq));
    wig_host_poll i_host (.clk_sys(clk_sys), .rst_n(rst_n), .poll_send(poll_send),
        .poll_nak(poll_nak), .poll_status(poll_status), .poll_req(poll_req),
        .answers(answers), .last_send(last_send), .last_status(last_status));
    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 check("reg_rdata", exp, reg_rdata);
    endtask
    task automatic fire(input logic [2:0] c, input logic [8:0] m);
        @(posedge clk_sys);
        ctl_pulse <= c;
        mac_events <= m;
        @(posedge clk_sys);
        ctl_pulse <= 3'h0;
        mac_events <= 9'h000;
    endtask
    task automatic poll_chk(input logic exp);
        logic [15:0] n;
        int k;
        n = answers;
        for (k = 0; k < 100 && answers < n + 16'h0002; k++) @(posedge clk_sys);
        #1 if (answers < n + 16'h0002) begin
            num_errors++;
            $display("MISMATCH poll answers expected 2 seen %0d", answers - n);
            close_out();
        end
        check("poll_send", {31'h0, exp}, {31'h0, last_send});
    endtask
    initial begin
        logic [31:0] img, wv;
        logic pol;
        void'($urandom(32'hD406DDC7));
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'h1;
        rd_chk(8'h64, 32'h00000000);
        rd_chk(8'h68, 32'h00000000);
        rd_chk(8'h84, 32'h00000000);
        rd_chk(8'h10, 32'h00000000);
        wr(8'h68, 32'hFFFFFFFF);
        rd_chk(8'h68, 32'h800FFFFF);
        img = $urandom;
        eeprom_present <= 1'h1;
        eeprom_wake_bytes <= img[15:0];
        fire(3'h4, 9'h000);
        rd_chk(8'h64, {21'h0, img[10:0]});
        wv = $urandom;
        wr(8'h64, wv);
        reset_protect <= 1'h1;
        fire(3'h1, 9'h000);
        rd_chk(8'h64, wv & 32'h87FF07FF);
        reset_protect <= 1'h0;
        fire(3'h2, 9'h000);
        rd_chk(8'h64, (wv & 32'h87FF0000) | {21'h0, img[10:0]});
        eeprom_present <= 1'h0;
        fire(3'h1, 9'h000);
        rd_chk(8'h64, wv & 32'h87FF0000);
        pin_is_gpio <= 11'h7FF;
        for (int i = 0; i < 11; i++) begin
            pol = 1'($urandom);
            pin_level[i] <= !pol;
            wr(8'h64, (32'h1 << i) | ({31'h0, pol} << (16 + i)));
            wr(8'h68, 32'h1 << i);
            wr(8'h84, 32'h1 << i);
            repeat (5) @(posedge clk_sys);
            wr(8'h80, 32'hFFFFFFFF);
            repeat (3) @(posedge clk_sys);
            check("pin_wake idle", 32'h0, {31'h0, pin_wake});
            check("irq idle", 32'h0, {31'h0, irq});
            pin_level[i] <= pol;
            repeat (5) @(posedge clk_sys);
            check("pin_wake active", 32'h1, {31'h0, pin_wake});
            check("irq raised", 32'h1, {31'h0, irq});
            poll_chk(1'h1);
            check("poll_status pin", 32'h1, {31'h0, last_status[i]});
            wr(8'h80, 32'h1 << i);
            repeat (3) @(posedge clk_sys);
            check("irq cleared", 32'h0, {31'h0, irq});
            poll_chk(1'h0);
            pin_is_gpio[i] <= 1'h0;
            repeat (5) @(posedge clk_sys);
            check("pin_wake not gpio", 32'h0, {31'h0, pin_wake});
            pin_is_gpio[i] <= 1'h1;
            wr(8'h64, {31'h0, pol} << (16 + i));
            repeat (5) @(posedge clk_sys);
            check("pin_wake disabled", 32'h0, {31'h0, pin_wake});
        end
        for (int k = 0; k < 9; k++) begin
            wr(8'h68, 32'h800 << k);
            wr(8'h80, 32'hFFFFFFFF);
            fire(3'h0, 9'h1 << k);
            poll_chk(1'h1);
            wr(8'h68, ~(32'h800 << k) & 32'h000FFFFF);
            wr(8'h80, 32'hFFFFFFFF);
            fire(3'h0, 9'h1 << k);
            poll_chk(1'h0);
        end
        wr(8'h68, 32'h80000000);
        wr(8'h80, 32'hFFFFFFFF);
        poll_chk(1'h1);
        wr(8'h68, 32'h00000000);
        poll_chk(1'h0);
        wr(8'h64, 32'h80000000);
        pin7_link_cfg_ok <= 1'h1;
        link_up <= 1'h1;
        for (int ps = 0; ps < 4; ps++) begin
            power_state <= 2'(ps);
            repeat (6) @(posedge clk_sys);
            check("link_up_wake", {31'h0, ps == 1 || ps == 3}, {31'h0, link_up_wake});
        end
        close_out();
    end
endmodule // tb
bind wig_event_gate wig_event_gate_props #(.PINS(PINS)) i_props (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_is_gpio(pin_is_gpio),
    .power_state(power_state), .poll_req(poll_req), .poll_send(poll_send),
    .poll_nak(poll_nak), .poll_status(poll_status), .pin_wake(pin_wake),
    .link_up_wake(link_up_wake), .irq(irq));

// ===== tb/wig_event_gate_props.sv
/* checker for wig_event_gate: polling, read data, wake and irq relations.
   assumes one clk_sys domain and register writes seen at the top ports. */
`timescale 1ns/10ps
`include "wig_params.svh"
module wig_event_gate_props
    import wig_pkg::*;
#(
    parameter int PINS = 11
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [PINS-1:0] pin_is_gpio,
    input wire logic [1:0] power_state,
    input wire logic poll_req,
    input wire logic poll_send,
    input wire logic poll_nak,
    input wire logic [31:0] poll_status,
    input wire logic pin_wake,
    input wire logic link_up_wake,
    input wire logic irq
);
    logic [31:0] ctl_m;
    logic [31:0] mask_m;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // mirrors of the report control and mask registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_m <= 32'h00000000;
            mask_m <= 32'h00000000;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `WIG_OFS_REPORT_CTL) ctl_m <= reg_wdata & 32'h800FFFFF;
            if (reg_addr == `WIG_OFS_IRQ_MASK) mask_m <= reg_wdata & 32'h003FFFFF;
        end
    end
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
        else $error("read data not zero outside read cycle");
    chk_rdata_unmapped: assert property (reg_rd && !(reg_addr inside {8'h64, 8'h68, 8'h80,
        8'h84}) |=> reg_rdata == 32'h00000000) else $error("unmapped read not zero");
    chk_poll_answer: assert property (poll_req && clk_en |=> poll_send != poll_nak)
        else $error("poll not answered by exactly one of send and nak");
    chk_poll_cause: assert property ((poll_send || poll_nak) |-> $past(poll_req))
        else $error("poll answer without poll");
    chk_always_send: assert property (poll_req && ctl_m[31] |=> poll_send)
        else $error("always on poll not sent");
    chk_gated_nak: assert property (poll_req && ctl_m == 32'h00000000 |=> poll_nak)
        else $error("poll sent with every report enable clear");
    chk_snap_hold: assert property (!poll_send |-> $stable(poll_status))
        else $error("poll status moved without a send");
    chk_gpio_block: assert property (pin_is_gpio == '0 [*2] |=> !pin_wake)
        else $error("pin wake while no pin in gpio mode");
    chk_link_state: assert property (power_state inside {2'h0, 2'h2} [*2] |=> !link_up_wake)
        else $error("link up wake outside suspend 0 and 3");
    chk_irq_masked: assert property (mask_m == 32'h00000000 [*2] |=> !irq)
        else $error("irq high with mask clear");
endmodule // wig_event_gate_props

// ===== tb/wig_host_poll.sv
/* host model polling the interrupt endpoint at a fixed interval.
   assumes the design answers each poll one cycle later. */
`timescale 1ns/10ps
module wig_host_poll #(
    parameter int INTERVAL = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic poll_send,
    input wire logic poll_nak,
    input wire logic [31:0] poll_status,
    output logic poll_req,
    output logic [15:0] answers,
    output logic last_send,
    output logic [31:0] last_status
);
    logic [7:0] tick;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 8'h00;
            poll_req <= 1'h0;
        end else begin
            tick <= (tick == 8'(INTERVAL - 1)) ? 8'h00 : tick + 8'h01;
            poll_req <= (tick == 8'h00);
        end
    end
    // record each answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            answers <= 16'h0000;
            last_send <= 1'h0;
            last_status <= 32'h00000000;
        end else if (poll_send || poll_nak) begin
            answers <= answers + 16'h0001;
            last_send <= poll_send;
            if (poll_send) last_status <= poll_status;
        end
    end
endmodule // wig_host_poll
